// ---- rtl/pot_top.sv ----
`timescale 1ns/1ns
// Contract
// - terminal inactive until enable is written
// - function selects transmitter, limit or alert
// - travel 0-100% maps linearly onto 4-20 mA
// - direction picks which end gives 4 mA
// - on output fault drive configured fail state
// - transmitter fail low is below 3.6 mA
// - fail high above 22.5 mA, powered only
// - switch fail setting chooses closed or open
// - power loss always opens the switch
// - limit mode compares travel with trip percent
// - alert source picks deviation or pressure fallback
// - polarity picks closing side of trip/alert
module pot_top
   import pot_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // measured travel and alerts
   input  wire logic [9:0]  travel,
   input  wire logic        travel_upd,
   input  wire logic        alert_dev,
   input  wire logic        alert_pf,
   input  wire logic        alert_upd,
   // output circuit health and controller power
   input  wire logic        out_fault,
   input  wire logic        ctrl_power_ok,
   // terminal outputs
   output logic [14:0]      loop_ua,
   output logic             loop_en,
   output logic             sw_closed,
   output logic             irq
);
   pot_cfg_if cfg ();

   localparam logic [6:0]  TRIP_MAX = 7'h64;      // trip ceiling, 100 percent
   localparam logic [14:0] UA_3P6   = 15'h0E10;   // fail-low must stay under this
   localparam logic [14:0] UA_22P5  = 15'h57E4;   // fail-high must stay over this

   logic [7:0]      ctrl_q;       // control register
   logic [6:0]      trip_q;       // trip percent
   logic [ST_W-1:0] stat_q;       // sticky events
   logic [ST_W-1:0] mask_q;       // interrupt mask
   logic [ST_W-1:0] ev;           // this-cycle events
   logic [9:0]      travel_q;     // last travel sample for readback
   logic            sw_chg;       // switch about to change
   logic            fault_q;      // previous fault level
   logic            wr_acc;       // write access phase
   logic            rd_acc;       // read access phase
   logic            addr_ok;      // address is mapped
   logic [14:0]     loop_ua_q;
   logic            loop_en_q;
   logic            sw_closed_q;

   // bus: always ready in the access phase, no wait states
   assign pready  = 1'b1;
   assign addr_ok = paddr == CTRL_OFF || paddr == TRIP_OFF || paddr == TRAVEL_OFF ||
                    paddr == OUT_OFF  || paddr == STAT_OFF || paddr == MASK_OFF;
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   // unmapped addresses answer with an error, reads return zero
   assign pslverr = psel && penable && !addr_ok;

   // configuration fan-out
   assign cfg.enable    = ctrl_q[CTRL_EN_BIT];
   assign cfg.fn        = pot_fn_t'(ctrl_q[CTRL_FN_LSB +: 2]);
   assign cfg.dir_open  = ctrl_q[CTRL_DIR_BIT];
   assign cfg.pol_above = ctrl_q[CTRL_POL_BIT];
   assign cfg.fail_hi   = ctrl_q[CTRL_FHI_BIT];
   assign cfg.fail_cl   = ctrl_q[CTRL_FCL_BIT];
   assign cfg.src_pf    = ctrl_q[CTRL_SRC_BIT];
   assign cfg.trip_pct  = trip_q;

   // control register; resets disabled so the terminal stays dark
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_acc && paddr == CTRL_OFF) begin
         ctrl_q <= pwdata[7:0];
      end
   end

   // trip point, clamped to 100 percent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trip_q <= TRIP_RST[6:0];
      end else if (wr_acc && paddr == TRIP_OFF) begin
         // whole word compared, so a large value cannot alias into range
         trip_q <= (pwdata > 32'(TRIP_MAX)) ? TRIP_MAX : pwdata[6:0];
      end
   end

   // mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= '0;
      end else if (wr_acc && paddr == MASK_OFF) begin
         mask_q <= pwdata[ST_W-1:0];
      end
   end

   // travel readback sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         travel_q <= '0;
      end else if (travel_upd) begin
         travel_q <= travel;
      end
   end

   // fault edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= out_fault;
      end
   end

   assign ev[ST_SW_BIT]    = sw_chg;
   assign ev[ST_FAULT_BIT] = out_fault && !fault_q;

   // sticky status: read clears, but a new event in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else if (rd_acc && paddr == STAT_OFF) begin
         stat_q <= ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   assign irq = |(stat_q & mask_q);

   // read mux, combinational during access phase
   always_comb begin
      prdata = '0;
      if (rd_acc) begin
         unique case (paddr)
            CTRL_OFF:   prdata = {24'h000000, ctrl_q};
            TRIP_OFF:   prdata = {25'h0000000, trip_q};
            TRAVEL_OFF: prdata = {22'h000000, travel_q};
            OUT_OFF:    prdata = {15'h0000, sw_closed_q, loop_en_q, loop_ua_q};
            STAT_OFF:   prdata = {30'h00000000, stat_q};
            MASK_OFF:   prdata = {30'h00000000, mask_q};
            default:    prdata = '0;
         endcase
      end
   end

   pot_out_core u_core (
      .pclk          (pclk),
      .presetn       (presetn),
      .cfg           (cfg.core),
      .travel        (travel),
      .travel_upd    (travel_upd),
      .alert_dev     (alert_dev),
      .alert_pf      (alert_pf),
      .alert_upd     (alert_upd),
      .out_fault     (out_fault),
      .ctrl_power_ok (ctrl_power_ok),
      .loop_ua_q     (loop_ua_q),
      .loop_en_q     (loop_en_q),
      .sw_closed_q   (sw_closed_q),
      .sw_chg        (sw_chg)
   );

   assign loop_ua   = loop_ua_q;
   assign loop_en   = loop_en_q;
   assign sw_closed = sw_closed_q;

   // disabled terminal never drives loop or switch
   disabled_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg.enable |=> !loop_en && !sw_closed) else $error("output active while disabled");
   // zero travel, closed direction, gives 4 mA
   xmtr_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_XMTR && !out_fault && !cfg.dir_open && travel == '0)
      |=> loop_ua == MA4_UA) else $error("zero travel not 4 mA");
   // reversed direction at full travel gives 4 mA
   xmtr_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_XMTR && !out_fault && cfg.dir_open &&
       travel == TRAVEL_FULL) |=> loop_ua == MA4_UA) else $error("direction wrong");
   // fail low under 3.6 mA
   fail_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_XMTR && out_fault && !cfg.fail_hi)
      |=> loop_ua < UA_3P6) else $error("fail low too high");
   // fail high above 22.5 mA when powered
   fail_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_XMTR && out_fault && cfg.fail_hi && ctrl_power_ok)
      |=> loop_ua > UA_22P5) else $error("fail high too low");
   // limit switch follows travel vs trip on update, polarity above
   limit_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && ctrl_power_ok && !out_fault && cfg.fn == POT_FN_LIMIT &&
       cfg.pol_above && travel_upd)
      |=> sw_closed == ($past(travel) > 10'($past(trip_q)) * PCT_SCALE))
      else $error("limit switch wrong");
   // alert switch follows selected source, polarity below
   alert_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && ctrl_power_ok && !out_fault && cfg.fn == POT_FN_ALERT &&
       !cfg.pol_above && alert_upd)
      |=> sw_closed == !($past(cfg.src_pf) ? $past(alert_pf) : $past(alert_dev)))
      else $error("alert switch wrong");
   // a rising fault is recorded as a sticky event
   fault_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      (out_fault && !fault_q) |=> stat_q[ST_FAULT_BIT]) else $error("fault event lost");
   // reserved function keeps loop and switch dark
   fn_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_RSVD) |=> !loop_en && !sw_closed && loop_ua == FAIL_LO_UA)
      else $error("reserved function drives output");
   // switch functions never run the loop
   sw_no_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.fn == POT_FN_LIMIT || cfg.fn == POT_FN_ALERT) |=> !loop_en)
      else $error("loop on in switch mode");
   // transmitter function never closes the switch
   xmtr_open_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.fn == POT_FN_XMTR |=> !sw_closed) else $error("switch closed in transmitter mode");
   // enabled transmitter drives the loop
   xmtr_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_XMTR) |=> loop_en) else $error("transmitter not on");
   // disabled terminal parks the command at fail low
   dark_current_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg.enable |=> loop_ua == FAIL_LO_UA) else $error("loop current while disabled");
   // full travel, closed direction, gives the top of the span
   xmtr_full_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_XMTR && !out_fault && !cfg.dir_open &&
       travel == TRAVEL_FULL) |=> loop_ua == MA4_UA + SPAN_UA)
      else $error("full travel not top of span");
   // valid travel always lands inside the span, either direction
   xmtr_span_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_XMTR && !out_fault && travel <= TRAVEL_FULL)
      |=> loop_ua >= MA4_UA && loop_ua <= MA4_UA + SPAN_UA) else $error("loop outside span");
   // fault without controller power falls back to fail low
   fail_nopwr_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && cfg.fn == POT_FN_XMTR && out_fault && !ctrl_power_ok)
      |=> loop_ua < UA_3P6) else $error("fail state high without power");
   // fault in alert mode drives configured fail state
   alert_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_power_ok && cfg.enable && out_fault && cfg.fn == POT_FN_ALERT)
      |=> sw_closed == $past(cfg.fail_cl)) else $error("alert fail state wrong");
   // limit switch, polarity below, closes at or under the trip point
   limit_below_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && ctrl_power_ok && !out_fault && cfg.fn == POT_FN_LIMIT &&
       !cfg.pol_above && travel_upd)
      |=> sw_closed == !($past(travel) > 10'($past(trip_q)) * PCT_SCALE))
      else $error("limit switch below wrong");
   // alert switch, polarity above, closes while the alert is active
   alert_above_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && ctrl_power_ok && !out_fault && cfg.fn == POT_FN_ALERT &&
       cfg.pol_above && alert_upd)
      |=> sw_closed == ($past(cfg.src_pf) ? $past(alert_pf) : $past(alert_dev)))
      else $error("alert switch above wrong");
   // no update, no change: the switch has no timer and no hysteresis
   sw_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg.enable && ctrl_power_ok && !out_fault && !travel_upd && !alert_upd &&
       (cfg.fn == POT_FN_LIMIT || cfg.fn == POT_FN_ALERT)) |=> $stable(sw_closed))
      else $error("switch moved without update");
   // a switch change is recorded as a sticky event
   sw_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      sw_chg |=> stat_q[ST_SW_BIT]) else $error("switch event lost");
   // a recorded fault stays until status is read
   stat_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (stat_q[ST_FAULT_BIT] && !(rd_acc && paddr == STAT_OFF)) |=> stat_q[ST_FAULT_BIT])
      else $error("fault status dropped");
   // reading status with no new event clears it
   stat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == STAT_OFF && ev == '0) |=> stat_q == '0)
      else $error("status not cleared");
   // writes to unmapped offsets are ignored
   unmapped_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && !addr_ok) |=> $stable(ctrl_q) && $stable(trip_q) && $stable(mask_q))
      else $error("unmapped write landed");
   // control write lands at the access edge
   ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == CTRL_OFF) |=> ctrl_q == 8'($past(pwdata)))
      else $error("control write lost");
   // trip point never exceeds full travel
   trip_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      trip_q <= TRIP_MAX) else $error("trip point above 100 percent");
   // an in-range trip write is kept as written
   trip_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == TRIP_OFF && pwdata <= 32'(TRIP_MAX))
      |=> trip_q == 7'($past(pwdata))) else $error("trip write lost");
   // an out-of-range trip write is clamped, not wrapped
   trip_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == TRIP_OFF && pwdata > 32'(TRIP_MAX))
      |=> trip_q == TRIP_MAX) else $error("trip write not clamped");
endmodule : pot_top

// ---- rtl/pot_pkg.sv ----
package pot_pkg;
   // apb register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;  // enable, function, polarity, fail bits
   localparam logic [7:0] TRIP_OFF   = 8'h04;  // limit switch trip point, percent
   localparam logic [7:0] TRAVEL_OFF = 8'h08;  // latest calibrated travel, read only
   localparam logic [7:0] OUT_OFF    = 8'h0C;  // loop current command and switch state
   localparam logic [7:0] STAT_OFF   = 8'h10;  // sticky events, cleared by read
   localparam logic [7:0] MASK_OFF   = 8'h14;  // interrupt mask

   // control field positions
   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_FN_LSB   = 1;   // two bits
   localparam int CTRL_DIR_BIT  = 3;   // 1: 4 mA at valve open
   localparam int CTRL_POL_BIT  = 4;   // 1: closed above trip / alert active
   localparam int CTRL_FHI_BIT  = 5;   // transmitter fail high
   localparam int CTRL_FCL_BIT  = 6;   // switch fail closed
   localparam int CTRL_SRC_BIT  = 7;   // 1: pressure fallback alert
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] TRIP_RST = 8'h32;

   // status bits
   localparam int ST_SW_BIT    = 0;    // switch changed state
   localparam int ST_FAULT_BIT = 1;    // output circuit fault seen
   localparam int ST_W         = 2;

   // travel scale: 0..1000 means 0.0..100.0 percent
   localparam logic [9:0]  TRAVEL_FULL = 10'h3E8;
   // current in microamps
   localparam logic [14:0] MA4_UA      = 15'h0FA0;   // 4 mA
   localparam logic [14:0] SPAN_UA     = 15'h3E80;   // 16 mA span
   localparam logic [14:0] FAIL_LO_UA  = 15'h0DAC;   // 3.5 mA, below 3.6 mA
   localparam logic [14:0] FAIL_HI_UA  = 15'h5DC0;   // 24 mA, above 22.5 mA
   localparam logic [9:0]  PCT_SCALE   = 10'h00A;    // percent to travel units

   typedef enum logic [1:0] {
      POT_FN_XMTR  = 2'b00,
      POT_FN_LIMIT = 2'b01,
      POT_FN_ALERT = 2'b10,
      POT_FN_RSVD  = 2'b11
   } pot_fn_t;

   // loop current for a travel value, direction aware
   function automatic logic [14:0] pot_travel_to_ua(input logic [9:0] t, input logic dir);
      logic [9:0]  tt;
      logic [24:0] prod;
      tt   = dir ? 10'(TRAVEL_FULL - t) : t;
      prod = 25'(tt) * 25'(SPAN_UA);
      return 15'(MA4_UA + 15'(prod / 25'(TRAVEL_FULL)));
   endfunction : pot_travel_to_ua
endpackage : pot_pkg

// ---- rtl/pot_cfg_if.sv ----
`timescale 1ns/1ns
// configuration passed from the register file to the output logic
interface pot_cfg_if;
   import pot_pkg::*;
   logic       enable;     // terminal enabled by tool
   pot_fn_t    fn;         // function selector
   logic       dir_open;   // 4 mA means valve open
   logic       pol_above;  // switch closes above trip / alert active
   logic       fail_hi;    // transmitter fails high
   logic       fail_cl;    // switch fails closed
   logic       src_pf;     // alert source pressure fallback
   logic [6:0] trip_pct;   // trip point percent
   modport regs (output enable, fn, dir_open, pol_above, fail_hi, fail_cl, src_pf, trip_pct);
   modport core (input  enable, fn, dir_open, pol_above, fail_hi, fail_cl, src_pf, trip_pct);
endinterface : pot_cfg_if

// ---- rtl/pot_out_core.sv ----
`timescale 1ns/1ns
module pot_out_core
   import pot_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // configuration
   pot_cfg_if.core          cfg,
   // measured inputs
   input  wire logic [9:0]  travel,
   input  wire logic        travel_upd,
   input  wire logic        alert_dev,
   input  wire logic        alert_pf,
   input  wire logic        alert_upd,
   input  wire logic        out_fault,
   input  wire logic        ctrl_power_ok,
   // outputs
   output logic [14:0]      loop_ua_q,
   output logic             loop_en_q,
   output logic             sw_closed_q,
   output logic             sw_chg
);
   logic       cond;          // above trip or alert active
   logic       sw_d;          // next switch state
   logic       upd;           // any travel or alert update
   logic [9:0] trip_units;    // trip point in travel units

   assign trip_units = 10'(10'(cfg.trip_pct) * PCT_SCALE);
   assign upd        = travel_upd | alert_upd;

   // condition for switch: travel above trip, or selected alert active
   always_comb begin
      if (cfg.fn == POT_FN_LIMIT) begin
         cond = travel > trip_units;
      end else begin
         cond = cfg.src_pf ? alert_pf : alert_dev;
      end
   end

   // polarity picks which side closes; faults override; power loss opens
   always_comb begin
      sw_d = sw_closed_q;
      if (!ctrl_power_ok || !cfg.enable) begin
         sw_d = 1'b0;
      end else if (cfg.fn == POT_FN_LIMIT || cfg.fn == POT_FN_ALERT) begin
         if (out_fault) begin
            sw_d = cfg.fail_cl;
         end else if (upd) begin
            sw_d = cfg.pol_above ? cond : !cond;
         end
      end else begin
         sw_d = 1'b0;
      end
   end

   // switch state register, no hysteresis by design
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_closed_q <= 1'b0;
      end else begin
         sw_closed_q <= sw_d;
      end
   end

   assign sw_chg = sw_d != sw_closed_q;

   // transmitter current command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loop_ua_q <= FAIL_LO_UA;
         loop_en_q <= 1'b0;
      end else begin
         loop_en_q <= cfg.enable && cfg.fn == POT_FN_XMTR;
         if (!cfg.enable || cfg.fn != POT_FN_XMTR) begin
            loop_ua_q <= FAIL_LO_UA;
         end else if (out_fault) begin
            // fail high needs controller power; without it, go low
            loop_ua_q <= (cfg.fail_hi && ctrl_power_ok) ? FAIL_HI_UA
                                                       : FAIL_LO_UA;
         end else begin
            loop_ua_q <= pot_travel_to_ua(travel, cfg.dir_open);
         end
      end
   end

   // switch never closed while power is lost
   power_open_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl_power_ok |=> !sw_closed_q) else $error("switch closed without power");
   // fault in limit mode drives configured fail state
   sw_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_power_ok && cfg.enable && out_fault && cfg.fn == POT_FN_LIMIT)
      |=> sw_closed_q == $past(cfg.fail_cl)) else $error("switch fail state wrong");
endmodule : pot_out_core

// ---- dv/pot_loop_rx.sv ----
`timescale 1ns/1ns
// far side: loop current receiver and discrete switch input
module pot_loop_rx (
   // terminal side
   input  wire logic [14:0] loop_ua,
   input  wire logic        loop_en,
   input  wire logic        sw_closed,
   // bench control, breaks the output circuit on command only
   input  wire logic        brk,
   // what the receiver sees
   output logic [14:0]      ua_seen,
   output logic             sw_seen,
   output logic             out_fault
);
   // a loop that is not driven carries no current, not the last value
   assign ua_seen   = loop_en ? loop_ua : 15'h0000;
   // contact input simply follows the switch
   assign sw_seen   = sw_closed;
   // broken circuit reported as a level
   assign out_fault = brk;
endmodule : pot_loop_rx

// ---- dv/tb.sv ----
`timescale 1ns/1ns
module tb;
   import pot_pkg::*;
   logic        pclk = 1'b0;           // bus clock
   logic        presetn = 1'b0;        // reset, active low
   logic        psel = 1'b0;           // apb controls
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [9:0]  travel = 10'h000;      // measured inputs
   logic        travel_upd = 1'b0;
   logic        alert_dev = 1'b0;
   logic        alert_pf = 1'b0;
   logic        alert_upd = 1'b0;
   logic        out_fault;
   logic        ctrl_power_ok = 1'b1;
   logic        brk = 1'b0;            // fault request to far side
   logic [14:0] loop_ua;
   logic        loop_en;
   logic        sw_closed;
   logic        irq;
   logic [14:0] ua_seen;               // far side view
   logic        sw_seen;
   logic [31:0] rd;                    // last read data
   logic        err;                   // last slave error
   int          n_fail = 0;
   int          checked = 0;

   always #5 pclk = ~pclk;

   pot_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .travel, .travel_upd, .alert_dev, .alert_pf, .alert_upd, .out_fault,
      .ctrl_power_ok, .loop_ua, .loop_en, .sw_closed, .irq);
   pot_loop_rx rx (.loop_ua, .loop_en, .sw_closed, .brk, .ua_seen, .sw_seen, .out_fault);

   task stop_test;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb

   // travel sample pulse, then one edge for the registered answer
   task tu(input logic [9:0] t);
      @(posedge pclk);
      travel     <= t;
      travel_upd <= 1'b1;
      @(posedge pclk);
      travel_upd <= 1'b0;
      @(posedge pclk);
      #1;
   endtask : tu

   task au(input logic d, input logic p);
      @(posedge pclk);
      alert_dev <= d;
      alert_pf  <= p;
      alert_upd <= 1'b1;
      @(posedge pclk);
      alert_upd <= 1'b0;
      @(posedge pclk);
      #1;
   endtask : au

   // fault and power levels
   task lv(input logic f, input logic p);
      @(posedge pclk);
      brk           <= f;
      ctrl_power_ok <= p;
      repeat (2) @(posedge pclk);
      #1;
   endtask : lv

   // expected loop current, worked out independently
   function automatic logic [31:0] xua(input logic [31:0] t, input logic dir);
      return 32'(MA4_UA) + ((dir ? 32'(TRAVEL_FULL) - t : t) * 32'(SPAN_UA)) / 32'(TRAVEL_FULL);
   endfunction : xua

   task t_idle;
      tu(10'h1F4);
      chk(loop_en, 1'b0);
      chk(loop_ua, 32'(FAIL_LO_UA));
      chk(sw_closed, 1'b0);
      apb(1'b0, TRIP_OFF, 32'h0);
      chk(rd, 32'h32);
      apb(1'b0, 8'h18, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, 8'h18, 32'hFF);
      chk(err, 1'b1);
      apb(1'b0, CTRL_OFF, 32'h0);
      chk(rd, 32'h0);
      $display("test idle done");
   endtask : t_idle

   task t_xmtr;
      logic [9:0] tv [4];
      tv = '{10'h000, 10'h0FA, 10'h1F4, 10'h3E8};
      for (int d = 0; d < 2; d++) begin
         apb(1'b1, CTRL_OFF, d ? 32'h09 : 32'h01);
         foreach (tv[i]) begin
            tu(tv[i]);
            chk(ua_seen, xua(32'(tv[i]), d[0]));
         end
      end
      apb(1'b0, OUT_OFF, 32'h0);
      chk(rd, 32'h8FA0);
      apb(1'b0, TRAVEL_OFF, 32'h0);
      chk(rd, 32'h3E8);
      apb(1'b1, CTRL_OFF, 32'h07);
      tu(10'h1F4);
      chk(loop_en, 1'b0);
      $display("test transmitter done");
   endtask : t_xmtr

   task t_fail;
      apb(1'b1, MASK_OFF, 32'h3);
      apb(1'b0, MASK_OFF, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, CTRL_OFF, 32'h01);
      tu(10'h1F4);
      lv(1'b1, 1'b1);
      chk(loop_ua < 15'h0E10, 1'b1);
      chk(irq, 1'b1);
      apb(1'b0, STAT_OFF, 32'h0);
      chk(rd, 32'h2);
      chk(irq, 1'b0);
      apb(1'b1, CTRL_OFF, 32'h21);
      lv(1'b1, 1'b1);
      chk(loop_ua > 15'h57E4, 1'b1);
      lv(1'b1, 1'b0);
      chk(loop_ua < 15'h0E10, 1'b1);
      lv(1'b0, 1'b1);
      tu(10'h1F4);
      chk(ua_seen, 32'h2EE0);
      $display("test fail state done");
   endtask : t_fail

   task t_limit;
      apb(1'b1, MASK_OFF, 32'h0);
      apb(1'b1, TRIP_OFF, 32'h7F);
      apb(1'b0, TRIP_OFF, 32'h0);
      chk(rd, 32'h64);
      apb(1'b1, TRIP_OFF, 32'hC8);
      apb(1'b0, TRIP_OFF, 32'h0);
      chk(rd, 32'h64);
      apb(1'b1, TRIP_OFF, 32'h1E);
      apb(1'b1, CTRL_OFF, 32'h03);
      tu(10'h12C);
      chk(sw_seen, 1'b1);
      tu(10'h12D);
      chk(sw_seen, 1'b0);
      tu(10'h12C);
      chk(sw_seen, 1'b1);
      apb(1'b0, STAT_OFF, 32'h0);
      chk(rd[0], 1'b1);
      chk(irq, 1'b0);
      apb(1'b1, CTRL_OFF, 32'h13);
      tu(10'h12D);
      chk(sw_seen, 1'b1);
      apb(1'b1, CTRL_OFF, 32'h03);
      tu(10'h12C);
      lv(1'b1, 1'b1);
      chk(sw_seen, 1'b0);
      apb(1'b1, CTRL_OFF, 32'h43);
      lv(1'b1, 1'b1);
      chk(sw_seen, 1'b1);
      lv(1'b1, 1'b0);
      chk(sw_seen, 1'b0);
      lv(1'b0, 1'b1);
      $display("test limit switch done");
   endtask : t_limit

   task t_alert;
      apb(1'b1, CTRL_OFF, 32'h05);
      au(1'b1, 1'b0);
      chk(sw_seen, 1'b0);
      au(1'b0, 1'b1);
      chk(sw_seen, 1'b1);
      apb(1'b1, CTRL_OFF, 32'h85);
      au(1'b0, 1'b1);
      chk(sw_seen, 1'b0);
      apb(1'b1, CTRL_OFF, 32'h95);
      au(1'b1, 1'b0);
      chk(sw_seen, 1'b0);
      au(1'b0, 1'b1);
      chk(sw_seen, 1'b1);
      lv(1'b1, 1'b1);
      chk(sw_seen, 1'b0);
      lv(1'b0, 1'b1);
      $display("test alert switch done");
   endtask : t_alert

   // watchdog, far beyond the two hundred or so cycles the tests need
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_idle();
      t_xmtr();
      t_fail();
      t_limit();
      t_alert();
      stop_test();
   end
endmodule : tb
